// >>> design/uxf_top.sv
// Extended receive features of an async serial port with an APB slave.
`timescale 1ns/100ps
`include "uxf_consts.svh"
module uxf_top (
  input wire logic clock_in, // 100 MHz clock.
  input wire logic rstn_in, // Synchronous reset, active low.
  input wire logic psel_in, // APB select.
  input wire logic penable_in, // APB enable.
  input wire logic pwrite_in, // APB write.
  input wire logic [11:0] paddr_in, // APB byte address.
  input wire logic [31:0] pwdata_in, // APB write data.
  output logic [31:0] prdata_out, // APB read data.
  output logic pready_out, // APB ready.
  output logic pslverr_out, // APB error.
  input wire logic serial_in_pin, // Receive pin.
  input wire logic event_in, // Event channel receive input.
  input wire logic tx_line_in, // Transmitter serial output.
  output logic tx_pin_out, // Transmit pin.
  input wire logic other_wake_in, // System woken by another source.
  output logic osc_req_out, // Oscillator request.
  output logic clk_req_out, // All-clocks wake request.
  output logic irq_out // Shared receive interrupt.
);
  // --------------------------------------------------------------------
  // Registers and bus
  // --------------------------------------------------------------------
  uxf_pkg::uxf_ctrl_t ctrl_q;
  uxf_pkg::uxf_rx_state_t st_q;
  logic [15:0] baud_q;
  logic [7:0] txpl_q;
  logic [6:0] rxpl_q;
  logic [1:0] sleep_q;
  logic rxc_q, rxs_q, isf_q, wfb_q, brk_q;
  logic [8:0] rxdata_q;
  logic wr, rd, hit;
  assign wr = psel_in & penable_in & pwrite_in;
  assign rd = psel_in & penable_in & ~pwrite_in;
  assign pready_out = 1'b1;
  // Unmapped offsets answer with an error; everything is zero-wait.
  always_comb begin
    hit = 1'b1;
    case (paddr_in)
      `UXF_OFF_STATUS, `UXF_OFF_CTRLA, `UXF_OFF_CONTROL_TWO, `UXF_OFF_CTRLC,
      `UXF_OFF_BAUD, `UXF_OFF_EVCTRL, `UXF_OFF_TXPL, `UXF_OFF_RXPL,
      `UXF_OFF_RXDATA, `UXF_OFF_POWER: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end
  assign pslverr_out = psel_in & penable_in & ~hit;
  // Read mux, registered for a stable data output.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in & ~penable_in) begin
      case (paddr_in)
        `UXF_OFF_STATUS: prdata_out <= {27'h0, rxc_q, rxs_q, isf_q,
                                        brk_q, wfb_q};
        `UXF_OFF_CTRLA: prdata_out <= {28'h0, ctrl_q.rx_start_ie,
                                       ctrl_q.loopback, ctrl_q.bad_sync_ie,
                                       ctrl_q.rx_done_ie};
        `UXF_OFF_CONTROL_TWO: prdata_out <= {27'h0, ctrl_q.rx_en,
                                       ctrl_q.start_detect_enable,
                                       ctrl_q.receive_mode_field,
                                       ctrl_q.multidrop_address_mode};
        `UXF_OFF_CTRLC: prdata_out <= {26'h0, ctrl_q.comm_mode_field,
                                       ctrl_q.ir_tx_mode,
                                       ctrl_q.double_speed,
                                       ctrl_q.nine_bit};
        `UXF_OFF_BAUD: prdata_out <= {16'h0, baud_q};
        `UXF_OFF_EVCTRL: prdata_out <= {31'h0,
                                        ctrl_q.infrared_event_input_enable};
        `UXF_OFF_TXPL: prdata_out <= {24'h0, txpl_q};
        `UXF_OFF_RXPL: prdata_out <= {25'h0, rxpl_q};
        `UXF_OFF_RXDATA: prdata_out <= {23'h0, rxdata_q};
        `UXF_OFF_POWER: prdata_out <= {30'h0, sleep_q};
        default: prdata_out <= 32'h00000000;
      endcase
    end
  end
  // Control registers. Double speed is refused in infrared mode.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ctrl_q <= '0;
      txpl_q <= 8'h00;
      rxpl_q <= 7'h00;
      sleep_q <= `UXF_SLP_ACTIVE;
    end else if (wr) begin
      case (paddr_in)
        `UXF_OFF_CTRLA: begin
          ctrl_q.rx_start_ie <= pwdata_in[3];
          ctrl_q.loopback <= pwdata_in[2];
          ctrl_q.bad_sync_ie <= pwdata_in[1];
          ctrl_q.rx_done_ie <= pwdata_in[0];
        end
        `UXF_OFF_CONTROL_TWO: begin
          ctrl_q.rx_en <= pwdata_in[4];
          ctrl_q.start_detect_enable <= pwdata_in[3];
          ctrl_q.receive_mode_field <= pwdata_in[2:1];
          ctrl_q.multidrop_address_mode <= pwdata_in[0];
        end
        `UXF_OFF_CTRLC: begin
          ctrl_q.comm_mode_field <= pwdata_in[5:4];
          ctrl_q.ir_tx_mode <= pwdata_in[3:2];
          ctrl_q.double_speed <= pwdata_in[1] &
            (pwdata_in[5:4] != `UXF_COMM_MODE_FIELD_IR);
          ctrl_q.nine_bit <= pwdata_in[0];
        end
        `UXF_OFF_EVCTRL: ctrl_q.infrared_event_input_enable <=
          pwdata_in[0];
        `UXF_OFF_TXPL: txpl_q <= pwdata_in[7:0];
        `UXF_OFF_RXPL: rxpl_q <= pwdata_in[6:0];
        `UXF_OFF_POWER: sleep_q <= pwdata_in[1:0];
        default: ;
      endcase
    end
  end
  // --------------------------------------------------------------------
  // Input path
  // --------------------------------------------------------------------
  logic pin_s1_q, pin_s2_q, ev_s1_q, ev_s2_q;
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
      ev_s1_q <= 1'b1;
      ev_s2_q <= 1'b1;
    end else begin
      pin_s1_q <= serial_in_pin;
      pin_s2_q <= pin_s1_q;
      ev_s1_q <= event_in;
      ev_s2_q <= ev_s1_q;
    end
  end
  logic ir_mode, raw_in, line, line_q;
  assign ir_mode = ctrl_q.comm_mode_field == `UXF_COMM_MODE_FIELD_IR;
  // Event input replaces the pin only in infrared mode.
  assign raw_in = (ir_mode & ctrl_q.infrared_event_input_enable) ?
                  ev_s2_q : pin_s2_q;
  // Infrared decoder: pin low means pulse high; short pulses read as one.
  logic [6:0] pw_q;
  logic ir_bit;
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      pw_q <= 7'h00;
    end else if (!raw_in) begin
      if (pw_q != 7'h7F) pw_q <= pw_q + 7'h01;
    end else begin
      pw_q <= 7'h00;
    end
  end
  assign ir_bit = ~(~raw_in & (pw_q >= rxpl_q));
  // Loopback taps the transmitter before the pin.
  assign line = ctrl_q.loopback ? tx_line_in :
                (ir_mode ? ir_bit : raw_in);
  // --------------------------------------------------------------------
  // Bit timing and receiver
  // --------------------------------------------------------------------
  // One bit time is baud_q/64 clocks, from the 16-bit divider word.
  logic [15:0] bt_q;
  logic [9:0] bitlen;
  logic [3:0] bit_q;
  logic [8:0] sh_q;
  logic [7:0] low_q;
  logic mid, bit_end, use_auto, fall, rise, frame_done;
  assign bitlen = (baud_q[15:6] == 10'h000) ? 10'h001 : baud_q[15:6];
  assign mid = bt_q[9:0] == {1'b0, bitlen[9:1]};
  assign bit_end = bt_q[9:0] >= bitlen - 10'h001;
  assign fall = line_q & ~line;
  assign rise = ~line_q & line;
  assign use_auto = ctrl_q.receive_mode_field != `UXF_RXM_NORMAL;
  always_ff @(posedge clock_in) begin
    if (!rstn_in) line_q <= 1'b1;
    else line_q <= line;
  end
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      st_q <= uxf_pkg::UXF_IDLE;
      bt_q <= 16'h0000;
      bit_q <= 4'h0;
      sh_q <= 9'h000;
    end else if (!ctrl_q.rx_en) begin
      st_q <= uxf_pkg::UXF_IDLE;
    end else begin
      bt_q <= bit_end ? 16'h0000 : bt_q + 16'h0001;
      case (st_q)
        uxf_pkg::UXF_IDLE: begin
          bt_q <= 16'h0000;
          if (fall && !wfb_q) st_q <= uxf_pkg::UXF_START;
        end
        uxf_pkg::UXF_START: begin
          if (mid && line) st_q <= uxf_pkg::UXF_IDLE;
          else if (bit_end) begin
            st_q <= uxf_pkg::UXF_DATA;
            bit_q <= 4'h0;
          end
        end
        uxf_pkg::UXF_DATA: begin
          if (mid) sh_q <= {line, sh_q[8:1]};
          if (bit_end) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == (ctrl_q.nine_bit ? 4'h8 : 4'h7))
              st_q <= uxf_pkg::UXF_STOP;
          end
        end
        uxf_pkg::UXF_STOP: begin
          if (mid) st_q <= uxf_pkg::UXF_IDLE;
        end
        default: st_q <= uxf_pkg::UXF_IDLE;
      endcase
    end
  end
  assign frame_done = ctrl_q.rx_en & (st_q == uxf_pkg::UXF_STOP) & mid;
  // Frame type: ninth bit, else first stop bit.
  logic ftype, accept;
  logic [7:0] dbyte;
  assign dbyte = ctrl_q.nine_bit ? sh_q[7:0] : sh_q[8:1];
  assign ftype = ctrl_q.nine_bit ? sh_q[8] : line;
  assign accept = frame_done & (~ctrl_q.multidrop_address_mode | ftype)
                  & ~brk_q;
  // --------------------------------------------------------------------
  // Break detection and auto-baud
  // --------------------------------------------------------------------
  logic [15:0] meas_q, seg_q, first_q;
  logic [2:0] edges_q;
  logic sync_q, brk_hit, sync_bad, fst_q;
  logic [9:0] lt_q;
  // Low time in bit times; own timer, as the receiver idles mid-break.
  always_ff @(posedge clock_in) begin
    if (!rstn_in || line) begin
      low_q <= 8'h00;
      lt_q <= 10'h000;
    end else if (lt_q >= bitlen - 10'h001) begin
      lt_q <= 10'h000;
      if (low_q != 8'hFF) low_q <= low_q + 8'h01;
    end else begin
      lt_q <= lt_q + 10'h001;
    end
  end
  // A level held over twice the start bit cannot be a 0x55 sync.
  assign sync_bad = sync_q & fst_q & (seg_q > {first_q[14:0], 1'b0});
  assign brk_hit = use_auto & ((low_q > `UXF_BRK_BITS) & ~brk_q |
                               wfb_q & rise);
  // Measurement runs from the sync start bit over four fall edges.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      brk_q <= 1'b0;
      sync_q <= 1'b0;
      meas_q <= 16'h0000;
      edges_q <= 3'h0;
      seg_q <= 16'h0000;
      first_q <= 16'h0000;
      fst_q <= 1'b0;
    end else if (brk_hit) begin
      brk_q <= 1'b1;
      sync_q <= 1'b0;
      meas_q <= 16'h0000;
      edges_q <= 3'h0;
      seg_q <= 16'h0000;
      fst_q <= 1'b0;
    end else if (brk_q && !sync_q) begin
      if (fall) sync_q <= 1'b1;
    end else if (sync_q) begin
      meas_q <= meas_q + 16'h0001;
      seg_q <= (fall | rise) ? 16'h0000 : seg_q + 16'h0001;
      if (rise && !fst_q) begin
        first_q <= seg_q + 16'h0001;
        fst_q <= 1'b1;
      end
      if (fall) edges_q <= edges_q + 3'h1;
      if ((fall && edges_q == 3'h3) || sync_bad) begin
        sync_q <= 1'b0;
        brk_q <= 1'b0;
      end
    end
  end
  // End of sync: eight bit times measured, count*64/8 is the divider.
  logic sync_end, sync_ok;
  logic [15:0] new_baud;
  assign sync_end = sync_q & fall & (edges_q == 3'h3);
  assign new_baud = {meas_q[12:0] + 13'h0001, 3'b000};
  assign sync_ok = (ctrl_q.receive_mode_field == `UXF_RXM_GENERIC_AUTOBAUD_MODE) ?
                   (new_baud >= `UXF_BAUD_MIN) : 1'b1;
  // A sync that ends cleanly commits, in generic mode only at or above UXF_BAUD_MIN; a broken one leaves the baud alone.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      baud_q <= `UXF_BAUD_RST;
    end else if (wr && paddr_in == `UXF_OFF_BAUD) begin
      baud_q <= pwdata_in[15:0];
    end else if (sync_end && sync_ok) begin
      baud_q <= new_baud;
    end
  end
  // --------------------------------------------------------------------
  // Flags, sleep wake and interrupt
  // --------------------------------------------------------------------
  logic sfd_arm, start_ev, clr_status;
  logic [4:0] clr;
  assign clr_status = wr & (paddr_in == `UXF_OFF_STATUS);
  assign clr = clr_status ? pwdata_in[4:0] : 5'h00;
  assign sfd_arm = ctrl_q.start_detect_enable &
                   (ctrl_q.comm_mode_field == `UXF_COMM_MODE_FIELD_ASYNC) &
                   (sleep_q == `UXF_SLP_STANDBY);
  assign start_ev = sfd_arm & fall & (st_q == uxf_pkg::UXF_IDLE);
  // Hardware set wins over a same-cycle software clear.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      rxc_q <= 1'b0;
      rxs_q <= 1'b0;
      isf_q <= 1'b0;
      wfb_q <= 1'b0;
      rxdata_q <= 9'h000;
    end else begin
      if (accept) begin
        rxc_q <= 1'b1;
        rxdata_q <= {ftype & ctrl_q.nine_bit, dbyte};
      end else if (clr[4] || (rd && paddr_in == `UXF_OFF_RXDATA))
        rxc_q <= 1'b0;
      if (start_ev) rxs_q <= 1'b1;
      else if (clr[3]) rxs_q <= 1'b0;
      if (sync_bad && ctrl_q.receive_mode_field == `UXF_RXM_STRICT)
        isf_q <= 1'b1;
      else if (clr[2]) isf_q <= 1'b0;
      if (brk_hit) wfb_q <= 1'b0;
      else if (clr_status && pwdata_in[0]) wfb_q <= 1'b1;
    end
  end
  // Oscillator held through a frame; dropped on false start.
  assign osc_req_out = sfd_arm & (fall | st_q != uxf_pkg::UXF_IDLE)
                       | other_wake_in;
  assign clk_req_out = sfd_arm & (ctrl_q.rx_start_ie ? rxs_q :
                       (ctrl_q.rx_done_ie & rxc_q)) | other_wake_in;
  assign irq_out = rxc_q & ctrl_q.rx_done_ie | rxs_q & ctrl_q.rx_start_ie
                   | isf_q & ctrl_q.bad_sync_ie;
  // --------------------------------------------------------------------
  // Infrared encoder
  // --------------------------------------------------------------------
  // Pulse at each bit start of a zero; mode 0 3/16 bit, 1 programmed, 2 and 3 the whole bit.
  logic [15:0] tb_q;
  logic [9:0] txbit;
  logic txl_q, pulse;
  logic [13:0] w316;
  assign w316 = {4'h0, bitlen} * 14'h0003;
  assign txbit = bitlen;
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      tb_q <= 16'h0000;
      txl_q <= 1'b1;
    end else begin
      txl_q <= tx_line_in;
      if ((txl_q != tx_line_in) || tb_q[9:0] >= txbit - 10'h001)
        tb_q <= 16'h0000;
      else tb_q <= tb_q + 16'h0001;
    end
  end
  assign pulse = ~tx_line_in & ((ctrl_q.ir_tx_mode == 2'h0) ?
                 ({2'h0, tb_q} < {4'h0, w316[13:4]} + 18'h0) :
                 (ctrl_q.ir_tx_mode == 2'h1) ?
                 ({2'h0, tb_q} < {10'h000, txpl_q}) : 1'b1);
  always_ff @(posedge clock_in) begin
    if (!rstn_in) tx_pin_out <= 1'b1;
    else tx_pin_out <= ir_mode ? ~pulse : tx_line_in;
  end
endmodule

// >>> design/uxf_consts.svh
// Constants for the extended serial receive features block.
`ifndef UXF_CONSTS_SVH
`define UXF_CONSTS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define UXF_OFF_STATUS 12'h004
`define UXF_OFF_CTRLA 12'h008
`define UXF_OFF_CONTROL_TWO 12'h00C
`define UXF_OFF_CTRLC 12'h010
`define UXF_OFF_BAUD 12'h014
`define UXF_OFF_EVCTRL 12'h018
`define UXF_OFF_TXPL 12'h01C
`define UXF_OFF_RXPL 12'h020
`define UXF_OFF_RXDATA 12'h024
`define UXF_OFF_POWER 12'h028
// ----------------------------------------------------------------------
// Field values and limits
// ----------------------------------------------------------------------
`define UXF_BRK_BITS 8'h0B
`define UXF_SYNC_CHAR 8'h55
`define UXF_BAUD_MIN 16'h0064
`define UXF_COMM_MODE_FIELD_ASYNC 2'h0
`define UXF_COMM_MODE_FIELD_IR 2'h2
`define UXF_RXM_NORMAL 2'h0
`define UXF_RXM_GENERIC_AUTOBAUD_MODE 2'h1
`define UXF_RXM_STRICT 2'h2
`define UXF_SLP_ACTIVE 2'h0
`define UXF_SLP_IDLE 2'h1
`define UXF_SLP_STANDBY 2'h2
`define UXF_SLP_PDOWN 2'h3
`define UXF_BAUD_RST 16'h0000
`endif

// >>> design/uxf_pkg.sv
// Types shared by the extended serial receive features block.
package uxf_pkg;
  // Receiver states.
  typedef enum logic [2:0] {
    UXF_IDLE, UXF_START, UXF_DATA, UXF_STOP
  } uxf_rx_state_t;
  // Control fields written by software.
  typedef struct packed {
    logic rx_en;
    logic start_detect_enable;
    logic [1:0] receive_mode_field;
    logic multidrop_address_mode;
    logic loopback;
    logic double_speed;
    logic [1:0] comm_mode_field;
    logic [1:0] ir_tx_mode;
    logic nine_bit;
    logic rx_start_ie;
    logic rx_done_ie;
    logic bad_sync_ie;
    logic infrared_event_input_enable;
  } uxf_ctrl_t;
endpackage

// >>> dv/uxf_remote_node.sv
// Model of a remote asynchronous serial node driving one shared line.
`timescale 1ns/100ps
module uxf_remote_node (
  input wire logic clock_in, // Clock shared with the block.
  output logic line_out // Serial line, idle high.
);
  // The line idles high between frames, as a quiet async line does.
  initial line_out = 1'b1;
  // Holds one level for n clocks; it changes only just after an edge.
  task automatic hold(input logic lvl, input int n);
    line_out <= lvl;
    repeat (n) @(posedge clock_in);
  endtask
  // Start bit, data LSB first, frame type, then stop and idle.
  task automatic send_frame(input logic [7:0] d, input int nb,
                            input logic kind, input int bt);
    hold(1'b0, bt);
    for (int i = 0; i < nb; i++) begin
      hold((i == 8) ? kind : d[i], bt);
    end
    if (nb < 9) begin
      hold(kind, bt);
    end
    hold(1'b1, bt);
    hold(1'b1, bt);
  endtask
endmodule

// >>> dv/uxf_top_properties.sv
// Port-level checker for the extended serial receive features block.
`timescale 1ns/100ps
`include "uxf_consts.svh"
module uxf_top_properties (
  input wire logic clock_in, // Clock.
  input wire logic rstn_in, // Reset, active low.
  input wire logic psel_in, // APB select.
  input wire logic penable_in, // APB enable.
  input wire logic pwrite_in, // APB write.
  input wire logic [11:0] paddr_in, // APB address.
  input wire logic [31:0] pwdata_in, // APB write data.
  input wire logic [31:0] prdata_out, // APB read data.
  input wire logic pready_out, // APB ready.
  input wire logic pslverr_out, // APB error.
  input wire logic serial_in_pin, // Receive pin.
  input wire logic event_in, // Event input.
  input wire logic tx_line_in, // Transmitter output.
  input wire logic tx_pin_out, // Transmit pin.
  input wire logic other_wake_in, // Other wake source.
  input wire logic osc_req_out, // Oscillator request.
  input wire logic clk_req_out, // Clock wake request.
  input wire logic irq_out // Interrupt.
);
  // ----------------------------------------------------------------
  // Shadow of the control bits
  // ----------------------------------------------------------------
  logic acc, wr, mapped, clr, armed, standby;
  logic [3:0] ctrla_q;
  logic start_detect_enable_q;
  logic [1:0] comm_mode_field_q, sleep_q;
  assign acc = psel_in && penable_in;
  assign wr = acc && pwrite_in;
  assign mapped = paddr_in inside {`UXF_OFF_STATUS, `UXF_OFF_CTRLA,
    `UXF_OFF_CONTROL_TWO, `UXF_OFF_CTRLC, `UXF_OFF_BAUD, `UXF_OFF_EVCTRL,
    `UXF_OFF_TXPL, `UXF_OFF_RXPL, `UXF_OFF_RXDATA, `UXF_OFF_POWER};
  assign clr = (wr && (paddr_in == `UXF_OFF_STATUS ||
    paddr_in == `UXF_OFF_CTRLA)) ||
    (acc && !pwrite_in && paddr_in == `UXF_OFF_RXDATA);
  assign standby = sleep_q == `UXF_SLP_STANDBY && start_detect_enable_q;
  assign armed = standby && comm_mode_field_q == `UXF_COMM_MODE_FIELD_ASYNC;
  // Writes are mirrored so that gating can be judged from the pins.
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      ctrla_q <= 4'h0;
      start_detect_enable_q <= 1'b0;
      comm_mode_field_q <= 2'h0;
      sleep_q <= 2'h0;
    end else if (wr) begin
      if (paddr_in == `UXF_OFF_CTRLA) ctrla_q <= pwdata_in[3:0];
      if (paddr_in == `UXF_OFF_CONTROL_TWO) start_detect_enable_q <= pwdata_in[3];
      if (paddr_in == `UXF_OFF_CTRLC) comm_mode_field_q <= pwdata_in[5:4];
      if (paddr_in == `UXF_OFF_POWER) sleep_q <= pwdata_in[1:0];
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  sequence s_armed_fall;
    $fell(serial_in_pin) && armed && ctrla_q[3];
  endsequence
  sequence s_woken;
    ##[1:6] (osc_req_out && clk_req_out);
  endsequence
  a_ready_no_wait: assert property (acc |-> pready_out)
    else $error("pready low in access phase");
  a_unmapped_error: assert property (acc |-> pslverr_out == !mapped)
    else $error("pslverr does not match the address map");
  a_rdata_stands: assert property ($changed(prdata_out) |->
    $past(psel_in && !penable_in))
    else $error("read data changed outside a setup cycle");
  a_wake_in_standby: assert property ($rose(osc_req_out) |->
    armed || other_wake_in) else $error("oscillator woken outside standby");
  a_start_wakes: assert property (s_armed_fall |-> s_woken)
    else $error("start edge did not wake the clocks");
  a_osc_only: assert property (standby && !ctrla_q[3] &&
    !ctrla_q[1] && !ctrla_q[0] && !other_wake_in |-> !clk_req_out)
    else $error("clocks woken with interrupts disabled");
  a_irq_gated: assert property (!(ctrla_q[3] || ctrla_q[1] ||
    ctrla_q[0]) |-> !irq_out) else $error("irq without enable");
  a_irq_holds: assert property ($fell(irq_out) |-> $past(clr))
    else $error("irq dropped without software clearing");
  a_tx_pin_path: assert property (comm_mode_field_q != `UXF_COMM_MODE_FIELD_IR &&
    $past(comm_mode_field_q) != `UXF_COMM_MODE_FIELD_IR |-> tx_pin_out == $past(tx_line_in))
    else $error("transmit pin does not follow transmitter");
endmodule
bind uxf_top uxf_top_properties uxf_top_properties_i (
  .clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out),
  .serial_in_pin(serial_in_pin), .event_in(event_in),
  .tx_line_in(tx_line_in), .tx_pin_out(tx_pin_out),
  .other_wake_in(other_wake_in), .osc_req_out(osc_req_out),
  .clk_req_out(clk_req_out), .irq_out(irq_out));

// >>> dv/test_uxf_top.sv
// Self-checking bench for the extended serial receive features block.
`timescale 1ns/100ps
`include "uxf_consts.svh"
`define CHK(nm, ex, got) \
  begin \
    n_tests++; \
    if ((got) !== (ex)) begin \
      num_errors++; \
      $display("wrong value %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module test_uxf_top;
  logic clock_in, rstn_in, psel, penable, pwrite, event_in, other_wake;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, serial_pin, tx_line, tx_pin, osc, clk_req, irq;
  logic err;
  int num_errors = 0;
  int n_tests = 0;
  uxf_top uxf_top_i (.clock_in(clock_in), .rstn_in(rstn_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .serial_in_pin(serial_pin), .event_in(event_in),
    .tx_line_in(tx_line), .tx_pin_out(tx_pin),
    .other_wake_in(other_wake), .osc_req_out(osc),
    .clk_req_out(clk_req), .irq_out(irq));
  uxf_remote_node uxf_remote_node_i (.clock_in(clock_in),
    .line_out(serial_pin));
  uxf_remote_node uxf_remote_node_tx_i (.clock_in(clock_in),
    .line_out(tx_line));
  // ----------------------------------------------------------------
  // Clock, bus tasks and verdict
  // ----------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // One APB transfer; a spare cycle after it keeps drivers single-set.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge clock_in);
    penable <= 1'b1;
    @(posedge clock_in);
    while (pready !== 1'b1) @(posedge clock_in);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // The run takes some three and a half thousand cycles; this leaves margin.
  initial begin
    repeat (60000) @(posedge clock_in);
    num_errors++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, event_in, other_wake} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rstn_in = 1'b0;
    repeat (4) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    apb(0, `UXF_OFF_STATUS, 0);
    `CHK("status reset", 32'h0, rd)
    apb(0, `UXF_OFF_BAUD, 0);
    `CHK("baud reset", 32'h0, rd)
    apb(0, 12'h0FC, 0);
    `CHK("unmapped error", 1'b1, err)
    apb(1, `UXF_OFF_CTRLC, 32'h22);
    apb(0, `UXF_OFF_CTRLC, 0);
    `CHK("ir double speed", 32'h20, rd)
    apb(1, `UXF_OFF_CTRLC, 0);
    $display("test registers done");
    // Plain reception raises the shared interrupt until read.
    apb(1, `UXF_OFF_BAUD, 32'h400);
    apb(1, `UXF_OFF_CTRLA, 32'h1);
    apb(1, `UXF_OFF_CONTROL_TWO, 32'h10);
    uxf_remote_node_i.send_frame(8'hA5, 8, 1'b1, 16);
    `CHK("irq on receive", 1'b1, irq)
    apb(0, `UXF_OFF_RXDATA, 0);
    `CHK("rx data", 8'hA5, rd[7:0])
    `CHK("irq cleared", 1'b0, irq)
    $display("test receive done");
    // Address filtering with 8 and 9 data bits.
    for (int k = 0; k < 2; k++) begin
      apb(1, `UXF_OFF_CTRLC, k);
      apb(1, `UXF_OFF_CONTROL_TWO, 32'h11);
      uxf_remote_node_i.send_frame(8'h3C, 8 + k, 1'b0, 16);
      apb(0, `UXF_OFF_STATUS, 0);
      `CHK("data frame dropped", 1'b0, rd[4])
      uxf_remote_node_i.send_frame(8'hC3, 8 + k, 1'b1, 16);
      apb(0, `UXF_OFF_RXDATA, 0);
      `CHK("address frame", 8'hC3, rd[7:0])
      apb(1, `UXF_OFF_CONTROL_TWO, 32'h10);
      uxf_remote_node_i.send_frame(8'h3C, 8 + k, 1'b0, 16);
      apb(0, `UXF_OFF_RXDATA, 0);
      `CHK("data after address", 8'h3C, rd[7:0])
    end
    apb(1, `UXF_OFF_CTRLC, 0);
    $display("test multidrop done");
    // Single-wire: the pin stays idle, the transmitter is heard.
    apb(1, `UXF_OFF_CTRLA, 32'h5);
    uxf_remote_node_tx_i.send_frame(8'h96, 8, 1'b1, 16);
    apb(0, `UXF_OFF_RXDATA, 0);
    `CHK("loopback data", 8'h96, rd[7:0])
    apb(1, `UXF_OFF_CTRLA, 32'h1);
    $display("test loopback done");
    // Strict mode: 12 low bits make a break, sync at 8 clocks a bit.
    apb(1, `UXF_OFF_CONTROL_TWO, 32'h14);
    uxf_remote_node_i.hold(1'b0, 192);
    uxf_remote_node_i.hold(1'b1, 16);
    uxf_remote_node_i.send_frame(8'h55, 8, 1'b1, 8);
    apb(0, `UXF_OFF_BAUD, 0);
    `CHK("strict baud", 32'h200, rd)
    uxf_remote_node_i.hold(1'b0, 96);
    uxf_remote_node_i.hold(1'b1, 8);
    uxf_remote_node_i.send_frame(8'hD5, 8, 1'b1, 8);
    apb(0, `UXF_OFF_STATUS, 0);
    `CHK("bad sync flag", 1'b1, rd[2])
    apb(0, `UXF_OFF_BAUD, 0);
    `CHK("baud kept", 32'h200, rd)
    apb(1, `UXF_OFF_STATUS, 32'h4);
    apb(0, `UXF_OFF_STATUS, 0);
    `CHK("bad sync cleared", 1'b0, rd[2])
    $display("test strict done");
    // Generic mode: a short pulse is a break once wait-for-break is set.
    apb(1, `UXF_OFF_CONTROL_TWO, 32'h12);
    for (int b = 1; b < 5; b += 3) begin
      apb(1, `UXF_OFF_STATUS, 32'h1);
      uxf_remote_node_i.hold(1'b0, 3);
      uxf_remote_node_i.hold(1'b1, 8);
      uxf_remote_node_i.send_frame(8'h55, 8, 1'b1, b);
      uxf_remote_node_i.hold(1'b1, 100);
      apb(0, `UXF_OFF_BAUD, 0);
      `CHK("generic baud", (b == 1) ? 32'h200 : 32'h100, rd)
    end
    $display("test generic done");
    // Standby start detection, false start and other sleep modes.
    apb(1, `UXF_OFF_BAUD, 32'h400);
    apb(1, `UXF_OFF_CONTROL_TWO, 32'h18);
    apb(1, `UXF_OFF_CTRLA, 32'h8);
    apb(1, `UXF_OFF_POWER, `UXF_SLP_STANDBY);
    uxf_remote_node_i.send_frame(8'h81, 8, 1'b1, 16);
    apb(0, `UXF_OFF_STATUS, 0);
    `CHK("start flag", 1'b1, rd[3])
    apb(0, `UXF_OFF_RXDATA, 0);
    `CHK("woken frame", 8'h81, rd[7:0])
    apb(1, `UXF_OFF_STATUS, 32'h18);
    apb(1, `UXF_OFF_CTRLA, 32'h0);
    fork
      uxf_remote_node_i.send_frame(8'h7E, 8, 1'b1, 16);
      begin
        repeat (80) @(posedge clock_in);
        `CHK("osc in frame", 1'b1, osc)
        `CHK("clocks asleep", 1'b0, clk_req)
      end
    join
    uxf_remote_node_i.hold(1'b0, 2);
    uxf_remote_node_i.hold(1'b1, 60);
    `CHK("false start osc", 1'b0, osc)
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        apb(1, `UXF_OFF_STATUS, 32'h18);
        apb(1, `UXF_OFF_POWER, m);
        uxf_remote_node_i.send_frame(8'h42, 8, 1'b1, 16);
        apb(0, `UXF_OFF_STATUS, 0);
        `CHK("no start outside standby", 1'b0, rd[3])
      end
    end
    apb(1, `UXF_OFF_POWER, `UXF_SLP_ACTIVE);
    $display("test start detect done");
    report_and_stop();
  end
endmodule
